// >>> pjm_pkg.sv
package pjm_pkg;
    // timebase: 125 MHz, one tick every 100 ms
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    // limits in milliseconds
    localparam int unsigned PICK1_MS = 3200;
    localparam int unsigned PICK2_MS = 3000;
    localparam int unsigned REG_T2_MS = 4000;
    localparam int unsigned REG_T3_MS = 4500;
    localparam int unsigned FUS_DLY_MS = 1400;
    localparam int unsigned FJ_DLY_MS = 1600;
    localparam int unsigned FUS_STAY_A3_MS = 3400;
    localparam int unsigned FUS_STAY_A4_MS = 2500;
    localparam int unsigned FD_DLY_MS = 2400;
    localparam int unsigned FD_STAY_A3_MS = 4300;
    localparam int unsigned FD_STAY_A4_MS = 3400;
    localparam int unsigned AUTO_DLV_MS = 180000;
    // limits in ticks, a least time rounded down for the monitor
    localparam int unsigned TICK_W = 12;
    localparam logic [TICK_W-1:0] PICK1_T = TICK_W'(PICK1_MS / TICK_MS);
    localparam logic [TICK_W-1:0] PICK2_T = TICK_W'(PICK2_MS / TICK_MS);
    localparam logic [TICK_W-1:0] REG_T2_T = TICK_W'(REG_T2_MS / TICK_MS);
    localparam logic [TICK_W-1:0] REG_T3_T = TICK_W'(REG_T3_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FUS_DLY_T = TICK_W'(FUS_DLY_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FJ_DLY_T = TICK_W'(FJ_DLY_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FUS_A3_T = TICK_W'(FUS_STAY_A3_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FUS_A4_T = TICK_W'(FUS_STAY_A4_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FD_DLY_T = TICK_W'(FD_DLY_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FD_A3_T = TICK_W'(FD_STAY_A3_MS / TICK_MS);
    localparam logic [TICK_W-1:0] FD_A4_T = TICK_W'(FD_STAY_A4_MS / TICK_MS);
    localparam logic [TICK_W-1:0] AUTO_DLV_T = TICK_W'(AUTO_DLV_MS / TICK_MS);
    // jam class codes reported to the formatter
    typedef enum logic [3:0] {
        PJM_NONE, PJM_PICK1_DLY, PJM_PICK2_DLY, PJM_FUS1_DLY, PJM_FUS2_DLY,
        PJM_FUS_STAY, PJM_FD_DLY, PJM_FD_STAY, PJM_DOOR, PJM_RES_POWER,
        PJM_RES_AUTO, PJM_RES_SENSOR
    } pjm_code_type;
    // media sensors, high while media is present
    typedef struct packed {
        logic registration_sensor;
        logic fuser_jam_sensor;
        logic fuser_delivery_sensor;
        logic tray2_feed_sensor_second;
        logic tray2_feed_sensor_first;
        logic tray3_feed_sensor_second;
        logic tray3_feed_sensor_first;
        logic facedown_delivery_sensor;
    } pjm_sensor_type;
endpackage

// >>> pjm_monitor.sv
`timescale 1ns/1ps
module pjm_monitor #(
    parameter int unsigned TICK_CYC = pjm_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // paper-path sensors and switches (asynchronous pins)
    input wire pjm_pkg::pjm_sensor_type sensors,
    input wire logic tray2_media_out,
    input wire logic door_open,
    // engine sequence events (same clock)
    input wire logic pickup_start,
    input wire logic vsync_n,
    input wire logic size_a3,
    input wire logic startup_done,
    input wire logic fuser_at_temp,
    input wire logic auto_dlv_needed,
    input wire logic auto_dlv_cmd,
    input wire logic jam_clear,
    // formatter notifications
    output logic tray2_empty_ff,
    output logic jam_ff,
    output pjm_pkg::pjm_code_type jam_code_ff
);
    // refuse a tick period that the prescaler cannot count
    if (TICK_CYC < 2) begin : g_tick_check
        $error("tick period too short");
    end

    // two-stage synchronisers for pins
    pjm_pkg::pjm_sensor_type s_meta_ff, s_ff, s_old_ff;
    logic [1:0] out_meta_ff, door_meta_ff;
    logic door_old_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_meta_ff <= '0;
            s_ff <= '0;
            s_old_ff <= '0;
            out_meta_ff <= '0;
            door_meta_ff <= '0;
            door_old_ff <= 1'b0;
        end else begin
            s_meta_ff <= sensors;
            s_ff <= s_meta_ff;
            s_old_ff <= s_ff;
            out_meta_ff <= {out_meta_ff[0], tray2_media_out};
            door_meta_ff <= {door_meta_ff[0], door_open};
            door_old_ff <= door_meta_ff[1];
        end
    end

    // edge helpers hold real pin values only from the third edge after reset
    // gating them avoids a false door or sensor edge when a pin already stands high at reset
    logic [2:0] live_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) live_ff <= '0;
        else live_ff <= {live_ff[1:0], 1'b1};
    end

    // leading and trailing edge helpers
    function automatic logic rise(input logic now, input logic old);
        return now & ~old;
    endfunction
    function automatic logic fall(input logic now, input logic old);
        return ~now & old;
    endfunction

    // 100 ms tick
    logic [31:0] pre_ff;
    logic tick_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pre_ff <= '0;
            tick_ff <= 1'b0;
        end else if (pre_ff == TICK_CYC - 1) begin
            pre_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            pre_ff <= pre_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    // timers: each armed by a start event, stopped by its sensor
    localparam int NT = 10;
    logic [pjm_pkg::TICK_W-1:0] cnt_ff [NT];
    logic [NT-1:0] run_ff;
    logic [NT-1:0] start, stop, expire;
    logic [pjm_pkg::TICK_W-1:0] lim [NT];
    logic vs_old_ff;
    logic vs_fall;
    assign vs_fall = ~vsync_n & vs_old_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) vs_old_ff <= 1'b1;
        else vs_old_ff <= vsync_n;
    end

    always_comb begin
        // pickup stage 1
        start[0] = pickup_start;
        stop[0] = s_ff.tray2_feed_sensor_first | s_ff.tray3_feed_sensor_first;
        lim[0] = pjm_pkg::PICK1_T;
        // first feed to second feed, tray2 and tray3
        start[1] = live_ff[2] & rise(s_ff.tray2_feed_sensor_first, s_old_ff.tray2_feed_sensor_first);
        stop[1] = s_ff.tray2_feed_sensor_second;
        lim[1] = pjm_pkg::PICK2_T;
        start[2] = live_ff[2] & rise(s_ff.tray3_feed_sensor_first, s_old_ff.tray3_feed_sensor_first);
        stop[2] = s_ff.tray3_feed_sensor_second;
        lim[2] = pjm_pkg::PICK2_T;
        // second feed to registration
        start[3] = live_ff[2] & rise(s_ff.tray2_feed_sensor_second, s_old_ff.tray2_feed_sensor_second);
        stop[3] = s_ff.registration_sensor;
        lim[3] = pjm_pkg::REG_T2_T;
        start[4] = live_ff[2] & rise(s_ff.tray3_feed_sensor_second, s_old_ff.tray3_feed_sensor_second);
        stop[4] = s_ff.registration_sensor;
        lim[4] = pjm_pkg::REG_T3_T;
        // vsync-referenced arrivals
        start[5] = vs_fall;
        stop[5] = s_ff.fuser_delivery_sensor;
        lim[5] = pjm_pkg::FUS_DLY_T;
        start[6] = vs_fall;
        stop[6] = s_ff.fuser_jam_sensor;
        lim[6] = pjm_pkg::FJ_DLY_T;
        start[7] = vs_fall;
        stop[7] = s_ff.facedown_delivery_sensor;
        lim[7] = pjm_pkg::FD_DLY_T;
        // vsync-referenced clearances, trailing edge
        start[8] = vs_fall;
        stop[8] = fall(s_ff.fuser_delivery_sensor, s_old_ff.fuser_delivery_sensor);
        lim[8] = size_a3 ? pjm_pkg::FUS_A3_T : pjm_pkg::FUS_A4_T;
        start[9] = vs_fall;
        stop[9] = fall(s_ff.facedown_delivery_sensor, s_old_ff.facedown_delivery_sensor);
        lim[9] = size_a3 ? pjm_pkg::FD_A3_T : pjm_pkg::FD_A4_T;
        for (int i = 0; i < NT; i++) begin
            expire[i] = run_ff[i] & tick_ff & (cnt_ff[i] + 1'b1 >= lim[i]) & ~stop[i];
        end
    end

    // timer counters
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NT; i++) begin
            if (!rst_n || jam_clear || stop[i] || expire[i]) begin
                run_ff[i] <= 1'b0;
                cnt_ff[i] <= '0;
            end else if (start[i]) begin
                run_ff[i] <= 1'b1;
                cnt_ff[i] <= '0;
            end else if (run_ff[i] && tick_ff) begin
                cnt_ff[i] <= cnt_ff[i] + 1'b1;
            end
        end
    end

    // automatic delivery wait after a clear
    logic auto_run_ff;
    logic [pjm_pkg::TICK_W-1:0] auto_cnt_ff;
    logic auto_exp;
    assign auto_exp = auto_run_ff & tick_ff & (auto_cnt_ff + 1'b1 >= pjm_pkg::AUTO_DLV_T) & ~auto_dlv_cmd;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || auto_dlv_cmd || auto_exp) begin
            auto_run_ff <= 1'b0;
            auto_cnt_ff <= '0;
        end else if (jam_clear && auto_dlv_needed) begin
            auto_run_ff <= 1'b1;
            auto_cnt_ff <= '0;
        end else if (auto_run_ff && tick_ff) begin
            auto_cnt_ff <= auto_cnt_ff + 1'b1;
        end
    end

    // residual checks: startup once, recovery check once warm
    logic boot_chk_ff, rec_chk_ff;
    logic any_media, door_edge, res_power, res_sensor;
    assign any_media = s_ff.registration_sensor | s_ff.fuser_jam_sensor | s_ff.fuser_delivery_sensor
        | s_ff.facedown_delivery_sensor | s_ff.tray2_feed_sensor_first | s_ff.tray2_feed_sensor_second
        | s_ff.tray3_feed_sensor_first | s_ff.tray3_feed_sensor_second;
    assign door_edge = live_ff[2] & (door_meta_ff[1] ^ door_old_ff);
    assign res_power = boot_chk_ff & startup_done & s_ff.fuser_delivery_sensor & s_ff.fuser_jam_sensor;
    assign res_sensor = rec_chk_ff & startup_done & fuser_at_temp & ~auto_run_ff & (s_ff.registration_sensor
        | s_ff.fuser_jam_sensor | s_ff.fuser_delivery_sensor | s_ff.tray2_feed_sensor_second
        | s_ff.tray3_feed_sensor_second | s_ff.facedown_delivery_sensor);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            boot_chk_ff <= 1'b1;
            rec_chk_ff <= 1'b1;
        end else begin
            if (startup_done) boot_chk_ff <= 1'b0;
            if (jam_clear || auto_dlv_cmd) rec_chk_ff <= 1'b1;
            else if (fuser_at_temp && !auto_run_ff && startup_done) rec_chk_ff <= 1'b0;
        end
    end

    // jam code selection, fixed priority
    pjm_pkg::pjm_code_type nxt_code;
    always_comb begin
        nxt_code = pjm_pkg::PJM_NONE;
        if (door_edge && any_media) nxt_code = pjm_pkg::PJM_DOOR;
        else if (res_power) nxt_code = pjm_pkg::PJM_RES_POWER;
        else if (auto_exp) nxt_code = pjm_pkg::PJM_RES_AUTO;
        else if (res_sensor) nxt_code = pjm_pkg::PJM_RES_SENSOR;
        else if (expire[0]) nxt_code = pjm_pkg::PJM_PICK1_DLY;
        else if (|expire[4:1]) nxt_code = pjm_pkg::PJM_PICK2_DLY;
        else if (expire[5]) nxt_code = pjm_pkg::PJM_FUS1_DLY;
        else if (expire[6]) nxt_code = pjm_pkg::PJM_FUS2_DLY;
        else if (expire[7]) nxt_code = pjm_pkg::PJM_FD_DLY;
        else if (expire[8]) nxt_code = pjm_pkg::PJM_FUS_STAY;
        else if (expire[9]) nxt_code = pjm_pkg::PJM_FD_STAY;
    end

    // latched jam report; a new jam wins over a clear, first jam held
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            jam_ff <= 1'b0;
            jam_code_ff <= pjm_pkg::PJM_NONE;
        end else if (nxt_code != pjm_pkg::PJM_NONE && (!jam_ff || jam_clear)) begin
            // a jam found in the clear cycle replaces the cleared one
            jam_ff <= 1'b1;
            jam_code_ff <= nxt_code;
        end else if (jam_clear) begin
            jam_ff <= 1'b0;
            jam_code_ff <= pjm_pkg::PJM_NONE;
        end
    end

    // tray 2 empty notification
    always_ff @(posedge ref_clk) begin
        if (!rst_n) tray2_empty_ff <= 1'b0;
        else tray2_empty_ff <= out_meta_ff[1];
    end

    // checks
    property p_empty;
        @(posedge ref_clk) disable iff (!rst_n) out_meta_ff[1] |=> tray2_empty_ff;
    endproperty
    a_empty: assert property (p_empty) else $error("empty not reported");
    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n) jam_ff && !jam_clear |=> jam_ff && $stable(jam_code_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("jam code not held");
    property p_latch;
        @(posedge ref_clk) disable iff (!rst_n) !jam_ff && nxt_code != pjm_pkg::PJM_NONE |=> jam_ff;
    endproperty
    a_latch: assert property (p_latch) else $error("jam not latched");
    property p_door;
        @(posedge ref_clk) disable iff (!rst_n) !jam_ff && door_edge && any_media
            |=> jam_code_ff == pjm_pkg::PJM_DOOR;
    endproperty
    a_door: assert property (p_door) else $error("door jam missed");
    property p_pick1;
        @(posedge ref_clk) disable iff (!rst_n) !jam_ff && expire[0] && !door_edge && !res_power
            && !auto_exp && !res_sensor |=> jam_code_ff == pjm_pkg::PJM_PICK1_DLY;
    endproperty
    a_pick1: assert property (p_pick1) else $error("pickup jam missed");
    property p_res_pwr;
        @(posedge ref_clk) disable iff (!rst_n) !jam_ff && res_power && !(door_edge && any_media)
            |=> jam_code_ff == pjm_pkg::PJM_RES_POWER;
    endproperty
    a_res_pwr: assert property (p_res_pwr) else $error("startup residual missed");
    property p_fus_lim;
        @(posedge ref_clk) disable iff (!rst_n) expire[5] |-> cnt_ff[5] == pjm_pkg::FUS_DLY_T - 1'b1;
    endproperty
    a_fus_lim: assert property (p_fus_lim) else $error("fuser timer limit wrong");
    property p_auto;
        @(posedge ref_clk) disable iff (!rst_n) auto_exp |-> auto_cnt_ff == pjm_pkg::AUTO_DLV_T - 1'b1;
    endproperty
    a_auto: assert property (p_auto) else $error("auto delivery wait wrong");
endmodule // pjm_monitor

// >>> pjm_path_model.sv
`timescale 1ns/1ps
// sheet walker for the paper path: drives media sensors and the tray 2 media-out switch
module pjm_path_model #(
    parameter int STEP_CYC = 40
) (
    // clock
    input wire logic ref_clk,
    // sheet control from the bench
    input wire logic feed_go,
    input wire logic release_sheet,
    input wire logic tray3_sel,
    input wire logic [1:0] stall_stage,
    input wire pjm_pkg::pjm_sensor_type stuck,
    input wire logic tray_empty,
    // pins toward the monitor
    output pjm_pkg::pjm_sensor_type sensors,
    output logic tray2_media_out
);
    int cnt_ff = -1; // cycles since the pick, -1 while idle
    logic [1:0] stage_ff = 2'h0; // furthest sensor reached: first feed, second feed, registration
    // move the sheet on one sensor every STEP_CYC cycles until it stalls where the bench asked
    always_ff @(posedge ref_clk) begin
        if (release_sheet) begin
            cnt_ff <= -1;
            stage_ff <= 2'h0;
        end else if (feed_go) begin
            cnt_ff <= 0;
        end else if (cnt_ff >= 0) begin
            cnt_ff <= cnt_ff + 1;
            if ((cnt_ff % STEP_CYC) == STEP_CYC - 1 && stage_ff < stall_stage) begin
                stage_ff <= stage_ff + 2'h1;
            end
        end
    end
    // a long sheet covers every sensor it has reached, plus any sheet left stuck by the bench
    always_comb begin
        sensors = stuck;
        sensors.tray2_feed_sensor_first |= (stage_ff >= 2'h1) & !tray3_sel;
        sensors.tray3_feed_sensor_first |= (stage_ff >= 2'h1) & tray3_sel;
        sensors.tray2_feed_sensor_second |= (stage_ff >= 2'h2) & !tray3_sel;
        sensors.tray3_feed_sensor_second |= (stage_ff >= 2'h2) & tray3_sel;
        sensors.registration_sensor |= (stage_ff == 2'h3);
    end
    assign tray2_media_out = tray_empty; // switch level, high when the tray is empty
endmodule // pjm_path_model

// >>> pjm_monitor_test.sv
`timescale 1ns/1ps
// self-checking bench for the jam monitor, sheet walker on the sensor side
module pjm_monitor_test;
    localparam int TC = 10; // cycles per timebase tick, shortened for simulation
    // clock, reset and engine events
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic door_open = 1'b0;
    logic pickup_start = 1'b0;
    logic vsync_n = 1'b1;
    logic size_a3 = 1'b0;
    logic startup_done = 1'b0;
    logic fuser_at_temp = 1'b0;
    logic auto_dlv_needed = 1'b0;
    logic auto_dlv_cmd = 1'b0;
    logic jam_clear = 1'b0;
    // sheet walker controls
    logic feed_go = 1'b0;
    logic release_sheet = 1'b0;
    logic tray3_sel = 1'b0;
    logic [1:0] stall_stage = 2'h0;
    logic tray_empty = 1'b0;
    pjm_pkg::pjm_sensor_type stuck = '0;
    // pins and outputs
    pjm_pkg::pjm_sensor_type sensors;
    logic tray2_media_out;
    logic tray2_empty_ff;
    logic jam_ff;
    pjm_pkg::pjm_code_type jam_code_ff;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #4 ref_clk = ~ref_clk;
    pjm_path_model path_u (.ref_clk(ref_clk), .feed_go(feed_go), .release_sheet(release_sheet),
        .tray3_sel(tray3_sel), .stall_stage(stall_stage), .stuck(stuck), .tray_empty(tray_empty),
        .sensors(sensors), .tray2_media_out(tray2_media_out));
    pjm_monitor #(.TICK_CYC(TC)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .sensors(sensors),
        .tray2_media_out(tray2_media_out), .door_open(door_open), .pickup_start(pickup_start),
        .vsync_n(vsync_n), .size_a3(size_a3), .startup_done(startup_done), .fuser_at_temp(fuser_at_temp),
        .auto_dlv_needed(auto_dlv_needed), .auto_dlv_cmd(auto_dlv_cmd), .jam_clear(jam_clear),
        .tray2_empty_ff(tray2_empty_ff), .jam_ff(jam_ff), .jam_code_ff(jam_code_ff));
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            summarize();
        end
    end
    task automatic step(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // quiet until one tick short of the limit, then the code within a tick plus sync slack
    task automatic expect_jam(pjm_pkg::pjm_code_type code, int t, int ofs);
        int n = 0;
        step((t - 1) * TC - ofs - 2);
        check("early jam", 1'b0, jam_ff);
        while (jam_ff !== 1'b1 && n < TC + 14) begin
            step(1);
            n++;
        end
        check("jam flag", 1'b1, jam_ff);
        check("jam code", code, jam_code_ff);
    endtask
    // empty the path, then clear the jam
    task automatic clear_path();
        stuck = '0;
        release_sheet = 1'b1;
        step(5);
        release_sheet = 1'b0;
        jam_clear = 1'b1;
        step(1);
        jam_clear = 1'b0;
        step(2);
        check("jam cleared", 1'b0, jam_ff);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        step(6);
        rst_n = 1'b1;
        step(1);
        check("jam after reset", 1'b0, jam_ff);
        check("code after reset", pjm_pkg::PJM_NONE, jam_code_ff);
    endtask
    task automatic pick_case(logic t3, logic [1:0] stall, pjm_pkg::pjm_code_type code, int t);
        tray3_sel = t3;
        stall_stage = stall;
        pickup_start = 1'b1;
        feed_go = 1'b1;
        step(1);
        pickup_start = 1'b0;
        feed_go = 1'b0;
        expect_jam(code, t, -40 * int'(stall));
        clear_path();
    endtask
    // vsync, early sheet state after 20 cycles, later state after 100 cycles
    task automatic vs_case(logic a3, logic [7:0] early, logic [7:0] late, pjm_pkg::pjm_code_type code, int t);
        size_a3 = a3;
        vsync_n = 1'b0;
        step(1);
        vsync_n = 1'b1;
        step(19);
        stuck = early;
        step(80);
        stuck = late;
        expect_jam(code, t, 100);
        clear_path();
    endtask
    task automatic t_tray();
        tray_empty = 1'b1;
        step(4);
        check("tray2 empty", 1'b1, tray2_empty_ff);
        tray_empty = 1'b0;
        step(4);
        check("tray2 empty", 1'b0, tray2_empty_ff);
        $display("tray test done");
    endtask
    task automatic t_pick();
        pick_case(1'b0, 2'h0, pjm_pkg::PJM_PICK1_DLY, int'(pjm_pkg::PICK1_T));
        pick_case(1'b0, 2'h1, pjm_pkg::PJM_PICK2_DLY, int'(pjm_pkg::PICK2_T));
        pick_case(1'b1, 2'h1, pjm_pkg::PJM_PICK2_DLY, int'(pjm_pkg::PICK2_T));
        pick_case(1'b0, 2'h2, pjm_pkg::PJM_PICK2_DLY, int'(pjm_pkg::REG_T2_T));
        pick_case(1'b1, 2'h2, pjm_pkg::PJM_PICK2_DLY, int'(pjm_pkg::REG_T3_T));
        $display("pickup test done");
    endtask
    task automatic t_vsync();
        vs_case(1'b0, 8'h00, 8'h00, pjm_pkg::PJM_FUS1_DLY, int'(pjm_pkg::FUS_DLY_T));
        vs_case(1'b0, 8'h20, 8'h20, pjm_pkg::PJM_FUS2_DLY, int'(pjm_pkg::FJ_DLY_T));
        vs_case(1'b0, 8'h60, 8'h61, pjm_pkg::PJM_FUS_STAY, int'(pjm_pkg::FUS_A4_T));
        vs_case(1'b1, 8'h60, 8'h61, pjm_pkg::PJM_FUS_STAY, int'(pjm_pkg::FUS_A3_T));
        vs_case(1'b1, 8'h60, 8'h40, pjm_pkg::PJM_FD_DLY, int'(pjm_pkg::FD_DLY_T));
        vs_case(1'b0, 8'h60, 8'h41, pjm_pkg::PJM_FD_STAY, int'(pjm_pkg::FD_A4_T));
        vs_case(1'b1, 8'h60, 8'h41, pjm_pkg::PJM_FD_STAY, int'(pjm_pkg::FD_A3_T));
        $display("vsync test done");
    endtask
    // door changes with an empty path, then with each sensor covered in turn
    task automatic t_door();
        door_open = 1'b1;
        step(10);
        check("door no media", 1'b0, jam_ff);
        for (int i = 0; i < 8; i++) begin
            stuck = pjm_pkg::pjm_sensor_type'(8'h01 << i);
            step(5);
            door_open = !door_open;
            expect_jam(pjm_pkg::PJM_DOOR, 1, -2);
            clear_path();
        end
        $display("door test done");
    endtask
    // first clear is followed by a delivery command, the second is not
    task automatic t_auto();
        for (int k = 0; k < 2; k++) begin
            stuck = 8'h80;
            step(5);
            door_open = !door_open;
            step(10);
            auto_dlv_needed = 1'b1;
            clear_path();
            auto_dlv_needed = 1'b0;
            if (k == 0) begin
                step(1000);
                auto_dlv_cmd = 1'b1;
                step(1);
                auto_dlv_cmd = 1'b0;
                step(18500);
                check("jam after delivery", 1'b0, jam_ff);
            end
        end
        expect_jam(pjm_pkg::PJM_RES_AUTO, int'(pjm_pkg::AUTO_DLV_T), 3);
        clear_path();
        $display("auto delivery test done");
    endtask
    task automatic t_power();
        stuck = 8'h60;
        startup_done = 1'b0;
        fuser_at_temp = 1'b0;
        do_reset();
        step(5);
        startup_done = 1'b1;
        expect_jam(pjm_pkg::PJM_RES_POWER, 1, -2);
        stuck = 8'h10;
        startup_done = 1'b0;
        do_reset();
        step(5);
        startup_done = 1'b1;
        step(20);
        check("jam before warm", 1'b0, jam_ff);
        fuser_at_temp = 1'b1;
        expect_jam(pjm_pkg::PJM_RES_SENSOR, 1, -2);
        clear_path();
        $display("power-on test done");
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        fuser_at_temp = 1'b1;
        startup_done = 1'b1;
        step(5);
        t_tray();
        t_pick();
        t_vsync();
        t_door();
        t_auto();
        t_power();
        summarize();
    end
endmodule // pjm_monitor_test
